// File: bench/spi_master_model.sv
// Behavioural serial bus master that drives the front end's pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model (
  input wire logic clk,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic oe_seen
);
  // Half a serial clock period in system cycles: 80 ns
  localparam int HALF = 20;
  logic idle_hi;

  initial
  begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
    oe_seen = 1'h0;
    idle_hi = 1'h0;
  end

  // Remembers whether the output was ever enabled during the frame
  always @(posedge clk)
  begin
    if (cs_n === 1'h0 && so_oe_n === 1'h0)
      oe_seen <= 1'h1;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // Power-up delay is covered by the idle cycles ahead of the select
  task automatic sel(input logic m3);
    wt(1);
    idle_hi = m3;
    sck = m3;
    wt(5);
    cs_n = 1'h0;
    oe_seen <= 1'h0;
    wt(HALF);
  endtask : sel

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'h0;
      si = tx[i];
      wt(HALF);
      sck = 1'h1;
      // Released line has no pull, so it shows the inverse of the last bit
      rx[i] = (so_oe_n === 1'h0) ? so_out : ~so_out;
      wt(HALF);
    end
  endtask : xfer

  // Released data line shows the inverse so a stale value never passes
  task automatic desel();
    sck = idle_hi;
    wt(HALF);
    cs_n = 1'h1;
    si = ~si;
    wt(8);
  endtask : desel
endmodule : spi_master_model
`default_nettype wire

// File: bench/tb_spi_front.sv
// Self-checking testbench for the serial memory command front end
`timescale 1ns/100ps
`default_nettype none
module tb_spi_front;
  logic clk, rst, wp_n, wr_ready, sck, cs_n, si, so_out, so_oe_n, oe_seen;
  logic spi_mode3, write_enable_flag, rd_strobe, wr_valid, wr_overflow;
  logic [7:0] status_byte, rd_data, wr_data, rx;
  logic [14:0] rd_addr, wr_addr, a;
  logic [7:0] ops [5];
  int bad_count, checks, cycles;
  int strobes, s0;

  // Memory stand-in: data is a fixed pattern of the address
  assign rd_data = rd_addr[7:0] ^ 8'h5A;

  spi_front spi_front_inst (.clk(clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .spi_mode3(spi_mode3),
    .write_enable_flag(write_enable_flag), .status_byte(status_byte), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_overflow(wr_overflow));

  spi_master_model spi_master_model_inst (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n),
    .sck(sck), .cs_n(cs_n), .si(si), .oe_seen(oe_seen));

  initial
  begin
    clk = 1'h0;
  end

  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // Access tasks and checking
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  // Counts memory fetch pulses so the read scenario can check them
  always @(posedge clk)
  begin
    if (rd_strobe === 1'h1)
      strobes++;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic sel(input logic m3);
    spi_master_model_inst.sel(m3);
  endtask : sel

  task automatic tx(input logic [7:0] b);
    spi_master_model_inst.xfer(b, rx);
  endtask : tx

  task automatic desel();
    spi_master_model_inst.desel();
  endtask : desel

  task automatic cmd(input logic m3, input logic [7:0] op);
    sel(m3);
    tx(op);
    desel();
  endtask : cmd

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'h1;
    wp_n = 1'h1;
    wr_ready = 1'h0;
    bad_count = 0;
    checks = 0;
    cycles = 0;
    repeat (3) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    check("flag", write_enable_flag, 1'h0);
    check("status", status_byte, 8'h00);
    check("oe_n", so_oe_n, 1'h1);
    sel(1'h0);
    tx(spi_front_pkg::STATUS_READ_CMD);
    tx(8'h00);
    desel();
    check("status rx", rx, 8'h00);
    check("mode3", spi_mode3, 1'h0);
    check("oe_n", so_oe_n, 1'h1);
    cmd(1'h1, spi_front_pkg::SET_WRITE_LATCH_CMD);
    check("flag", write_enable_flag, 1'h1);
    check("mode3", spi_mode3, 1'h1);
    sel(1'h1);
    tx(spi_front_pkg::STATUS_READ_CMD);
    tx(8'h00);
    desel();
    check("status rx", rx, 8'h02);
    cmd(1'h0, spi_front_pkg::CLEAR_WRITE_LATCH_CMD);
    check("flag", write_enable_flag, 1'h0);
    // Status write: bit 1 and fixed bits in the data must not land
    cmd(1'h0, spi_front_pkg::SET_WRITE_LATCH_CMD);
    sel(1'h0);
    tx(spi_front_pkg::STATUS_WRITE_CMD);
    tx(8'hF3);
    check("flag", write_enable_flag, 1'h1);
    desel();
    check("status", status_byte, 8'h80);
    check("flag", write_enable_flag, 1'h0);
    // Write-protect pin low with the enable bit set refuses the write
    cmd(1'h0, spi_front_pkg::SET_WRITE_LATCH_CMD);
    wp_n = 1'h0;
    sel(1'h0);
    tx(spi_front_pkg::STATUS_WRITE_CMD);
    tx(8'h0C);
    desel();
    wp_n = 1'h1;
    check("status", status_byte, 8'h80);
    check("flag", write_enable_flag, 1'h0);
    sel(1'h0);
    tx(spi_front_pkg::WRITE_CMD);
    tx(8'h00);
    tx(8'h10);
    tx(8'h55);
    desel();
    check("wr_valid", wr_valid, 1'h0);
    // Burst with top address bit set, rollover, and one byte too many
    cmd(1'h1, spi_front_pkg::SET_WRITE_LATCH_CMD);
    sel(1'h1);
    tx(spi_front_pkg::WRITE_CMD);
    tx(8'hFF);
    tx(8'hFF);
    for (int k = 0; k < 9; k++)
      tx(8'hA0 + 8'(k));
    desel();
    check("overflow", wr_overflow, 1'h1);
    check("flag", write_enable_flag, 1'h0);
    for (int k = 0; k < 8; k++)
    begin
      a = 15'h7FFF + 15'(k);
      check("wr_valid", wr_valid, 1'h1);
      check("wr_addr", wr_addr, a);
      check("wr_data", wr_data, 8'hA0 + 8'(k));
      wr_ready = 1'h1;
      @(negedge clk);
      wr_ready = 1'h0;
      @(negedge clk);
    end
    check("wr_valid", wr_valid, 1'h0);
    // Protect the upper quarter; a burst stops at its first protected byte
    cmd(1'h0, spi_front_pkg::SET_WRITE_LATCH_CMD);
    sel(1'h0);
    tx(spi_front_pkg::STATUS_WRITE_CMD);
    tx(8'h84);
    desel();
    check("status", status_byte, 8'h84);
    cmd(1'h0, spi_front_pkg::SET_WRITE_LATCH_CMD);
    sel(1'h0);
    tx(spi_front_pkg::WRITE_CMD);
    tx(8'h5F);
    tx(8'hFF);
    tx(8'h11);
    tx(8'h22);
    desel();
    check("wr_valid", wr_valid, 1'h1);
    check("wr_addr", wr_addr, 15'h5FFF);
    check("wr_data", wr_data, 8'h11);
    wr_ready = 1'h1;
    @(negedge clk);
    wr_ready = 1'h0;
    @(negedge clk);
    check("wr_valid", wr_valid, 1'h0);
    // Read in mode 3 so deselection brings no extra falling edge
    s0 = strobes;
    sel(1'h1);
    tx(spi_front_pkg::READ_CMD);
    tx(8'h80);
    tx(8'h10);
    tx(8'h00);
    check("read rx", rx, 8'h4A);
    tx(8'h00);
    check("read rx", rx, 8'h4B);
    desel();
    check("rd_addr", rd_addr, 15'h0012);
    check("rd_strobe count", 16'(strobes - s0), 16'h0002);
    sel(1'h0);
    tx(spi_front_pkg::FAST_READ_CMD);
    tx(8'h00);
    tx(8'h20);
    tx(8'h00);
    tx(8'h00);
    desel();
    check("fast rx", rx, 8'h7A);
    // Opcodes that give no output; a second opcode in the frame is ignored
    ops = '{spi_front_pkg::SLEEP_CMD, spi_front_pkg::IDENT_READ_CMD, 8'hC3, 8'h5A,
      spi_front_pkg::CLEAR_WRITE_LATCH_CMD};
    for (int k = 0; k < 5; k++)
    begin
      sel(1'h0);
      tx(ops[k]);
      tx(spi_front_pkg::SET_WRITE_LATCH_CMD);
      tx(spi_front_pkg::STATUS_READ_CMD);
      desel();
      check("oe seen", oe_seen, 1'h0);
      check("flag", write_enable_flag, 1'h0);
    end
    tally_and_finish();
  end
endmodule : tb_spi_front
`default_nettype wire

// File: rtl/spi_front.sv
// Serial memory command front end with its write-data FIFO
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Write-data FIFO
// ------------------------------------------------------------------
module write_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } fifo_state_type;

  fifo_state_type r;
  fifo_state_type n;
  logic push;
  logic pop;

  assign in_ready = (r.count != FULL_COUNT);
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wptr] = in_data;
      n.wptr = (r.wptr == PW'(DEPTH - 1)) ? '0 : r.wptr + PW'(1);
    end
    if (pop)
    begin
      n.rptr = (r.rptr == PW'(DEPTH - 1)) ? '0 : r.rptr + PW'(1);
    end
    if (push && !pop)
    begin
      n.count = r.count + CW'(1);
    end
    else if (pop && !push)
    begin
      n.count = r.count - CW'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end
endmodule : write_fifo

// ------------------------------------------------------------------
// Serial front end
// ------------------------------------------------------------------
module spi_front (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n,
  output logic spi_mode3,
  output logic write_enable_flag,
  output logic [7:0] status_byte,
  output logic [14:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic rd_strobe,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [14:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_overflow
);

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    logic [1:0] wp_s;
    spi_front_pkg::phase_type phase;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic addr_hi;
    logic [14:0] addr;
    logic fast;
    logic is_write;
    logic mode3;
    logic we_latch;
    logic clr_on_end;
    logic wpen;
    logic [1:0] bp;
    logic so;
    logic drive;
    logic rd_strobe;
    logic push;
    logic [22:0] push_data;
    logic overflow;
  } front_state_type;

  front_state_type r;
  front_state_type n;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_now;
  logic [7:0] status;
  logic fifo_ready;
  logic [22:0] fifo_out;

  // Block protection decided from the two protect bits
  function automatic logic is_protected(input logic [1:0] bp, input logic [14:0] a);
    logic p;
    p = 1'b0;
    unique case (bp)
      2'h0: p = 1'b0;
      2'h1: p = (a >= spi_front_pkg::QUARTER_BASE);
      2'h2: p = (a >= spi_front_pkg::HALF_BASE);
      2'h3: p = 1'b1;
    endcase
    return p;
  endfunction : is_protected

  // ----------------------------------------------------------------
  // Edge detection on synchronised pins
  // ----------------------------------------------------------------
  // Edges compare the second and third stages; the first stage only feeds
  // the second, keeping metastability out of the decode.
  assign sck_rise = r.sck_s[1] && !r.sck_s[2];
  assign sck_fall = !r.sck_s[1] && r.sck_s[2];
  assign cs_fall = !r.cs_s[1] && r.cs_s[2];
  assign cs_rise = r.cs_s[1] && !r.cs_s[2];
  assign byte_now = {r.sh[6:0], r.si_s[1]};

  always_comb
  begin
    status = '0;
    status[spi_front_pkg::STAT_WPEN_POS] = r.wpen;
    status[spi_front_pkg::STAT_BP1_POS] = r.bp[1];
    status[spi_front_pkg::STAT_BP0_POS] = r.bp[0];
    status[spi_front_pkg::STAT_WRITE_ENABLE_POS] = r.we_latch;
  end

  // ----------------------------------------------------------------
  // Frame decoding
  // ----------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.rd_strobe = 1'b0;
    n.push = 1'b0;
    n.sck_s = {r.sck_s[1:0], sck};
    n.cs_s = {r.cs_s[1:0], cs_n};
    n.si_s = {r.si_s[0], si};
    n.wp_s = {r.wp_s[0], wp_n};
    if (r.cs_s[1])
    begin
      // Deselected: input ignored, output released
      if (cs_rise && r.clr_on_end)
      begin
        n.we_latch = 1'b0;
      end
      n.phase = spi_front_pkg::PH_IDLE;
      n.drive = 1'b0;
      n.clr_on_end = 1'b0;
    end
    else if (cs_fall)
    begin
      n.mode3 = r.sck_s[1];
      n.phase = spi_front_pkg::PH_OPCODE;
      n.cnt = '0;
      n.addr_hi = 1'b0;
      n.drive = 1'b0;
    end
    else
    begin
      // Bit counting starts at the first rise, so a mode 3 initial fall does nothing
      if (sck_rise && r.phase != spi_front_pkg::PH_IDLE
          && r.phase != spi_front_pkg::PH_IGNORE)
      begin
        n.sh = byte_now;
        n.cnt = r.cnt + 3'h1;
        if (r.cnt == 3'h7)
        begin
          unique case (r.phase)
            spi_front_pkg::PH_OPCODE:
            begin
              n.phase = spi_front_pkg::PH_IGNORE;
              unique case (byte_now)
                spi_front_pkg::SET_WRITE_LATCH_CMD:
                  n.we_latch = 1'b1;
                spi_front_pkg::CLEAR_WRITE_LATCH_CMD:
                  n.clr_on_end = 1'b1;
                spi_front_pkg::STATUS_READ_CMD:
                begin
                  n.phase = spi_front_pkg::PH_STAT_OUT;
                  n.drive = 1'b1;
                end
                spi_front_pkg::STATUS_WRITE_CMD:
                begin
                  n.phase = spi_front_pkg::PH_STAT_IN;
                  n.clr_on_end = 1'b1;
                end
                spi_front_pkg::READ_CMD:
                begin
                  n.phase = spi_front_pkg::PH_ADDR;
                  n.fast = 1'b0;
                  n.is_write = 1'b0;
                end
                spi_front_pkg::FAST_READ_CMD:
                begin
                  n.phase = spi_front_pkg::PH_ADDR;
                  n.fast = 1'b1;
                  n.is_write = 1'b0;
                end
                spi_front_pkg::WRITE_CMD:
                begin
                  n.phase = spi_front_pkg::PH_ADDR;
                  n.is_write = 1'b1;
                  n.clr_on_end = 1'b1;
                end
                // Sleep and identification are accepted but served elsewhere
                spi_front_pkg::SLEEP_CMD,
                spi_front_pkg::IDENT_READ_CMD:
                  n.phase = spi_front_pkg::PH_IGNORE;
                default:
                  n.phase = spi_front_pkg::PH_IGNORE;
              endcase
            end
            spi_front_pkg::PH_ADDR:
            begin
              if (!r.addr_hi)
              begin
                n.addr[14:8] = byte_now[6:0];
                n.addr_hi = 1'b1;
              end
              else
              begin
                n.addr[7:0] = byte_now;
                if (r.is_write)
                begin
                  n.phase = spi_front_pkg::PH_WDATA;
                end
                else if (r.fast)
                begin
                  n.phase = spi_front_pkg::PH_DUMMY;
                end
                else
                begin
                  n.phase = spi_front_pkg::PH_RDATA;
                  n.drive = 1'b1;
                end
              end
            end
            spi_front_pkg::PH_DUMMY:
            begin
              n.phase = spi_front_pkg::PH_RDATA;
              n.drive = 1'b1;
            end
            spi_front_pkg::PH_STAT_IN:
            begin
              // Flag bit is not taken from the byte
              if (r.we_latch && !(r.wpen && !r.wp_s[1]))
              begin
                n.wpen = byte_now[spi_front_pkg::STAT_WPEN_POS];
                n.bp = {byte_now[spi_front_pkg::STAT_BP1_POS],
                        byte_now[spi_front_pkg::STAT_BP0_POS]};
              end
              n.phase = spi_front_pkg::PH_IGNORE;
            end
            spi_front_pkg::PH_WDATA:
            begin
              if (r.we_latch && !is_protected(r.bp, r.addr))
              begin
                n.push = 1'b1;
                n.push_data = {r.addr, byte_now};
                n.addr = r.addr + 15'h1;
                if (!fifo_ready)
                begin
                  n.overflow = 1'b1;
                end
              end
              else
              begin
                // Burst stops at a protected block
                n.phase = spi_front_pkg::PH_IGNORE;
              end
            end
            default:
            begin
              n.phase = r.phase;
            end
          endcase
        end
      end
      if (sck_fall && r.drive)
      begin
        if (r.cnt != 3'h0)
        begin
          n.so = r.tx[3'h7 - r.cnt];
        end
        else if (r.phase == spi_front_pkg::PH_RDATA)
        begin
          // Memory data fetched tens of cycles after the address settled
          n.tx = rd_data;
          n.so = rd_data[7];
          n.rd_strobe = 1'b1;
          n.addr = r.addr + 15'h1;
        end
        else
        begin
          n.tx = status;
          n.so = status[7];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      r <= '0;
      r.cs_s <= 3'h7;
      r.wp_s <= 2'h3;
      r.phase <= spi_front_pkg::PH_IDLE;
      r.we_latch <= spi_front_pkg::WRITE_ENABLE_RESET;
      r.wpen <= spi_front_pkg::WPEN_RESET;
      r.bp <= spi_front_pkg::BP_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Write-data FIFO and outputs
  // ----------------------------------------------------------------
  write_fifo #(
    .WIDTH(23),
    .DEPTH(spi_front_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(r.push),
    .in_ready(fifo_ready),
    .in_data(r.push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  assign wr_addr = fifo_out[22:8];
  assign wr_data = fifo_out[7:0];
  assign so_out = r.so;
  assign so_oe_n = !r.drive;
  assign spi_mode3 = r.mode3;
  assign write_enable_flag = r.we_latch;
  assign status_byte = status;
  assign rd_addr = r.addr;
  assign rd_strobe = r.rd_strobe;
  assign wr_overflow = r.overflow;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  deselect_release_a: assert property (@(posedge clk) disable iff (rst)
    r.cs_s[1] |=> so_oe_n)
    else $error("output driven while deselected");

  so_on_fall_a: assert property (@(posedge clk) disable iff (rst)
    $changed(so_out) |-> $past(sck_fall))
    else $error("serial output changed off a falling edge");

  mode_capture_a: assert property (@(posedge clk) disable iff (rst)
    cs_fall |=> (spi_mode3 == $past(r.sck_s[1])))
    else $error("mode not taken from clock level at selection");

  latch_set_a: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && !r.cs_s[1] && r.phase == spi_front_pkg::PH_OPCODE && r.cnt == 3'h7
     && byte_now == spi_front_pkg::SET_WRITE_LATCH_CMD)
    |=> write_enable_flag && status_byte[1])
    else $error("set latch opcode did not set the flag");

  latch_clear_a: assert property (@(posedge clk) disable iff (rst)
    (cs_rise && r.clr_on_end) |=> !write_enable_flag)
    else $error("latch not cleared at end of frame");

  status_keeps_flag_a: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && !r.cs_s[1] && r.phase == spi_front_pkg::PH_STAT_IN && r.cnt == 3'h7)
    |=> $stable(write_enable_flag))
    else $error("status write changed the flag");

  bad_opcode_a: assert property (@(posedge clk) disable iff (rst)
    (r.phase == spi_front_pkg::PH_IGNORE) [*2] |-> so_oe_n)
    else $error("output driven after an ignored opcode");

  status_shift_a: assert property (@(posedge clk) disable iff (rst)
    (sck_fall && !r.cs_s[1] && r.drive && r.cnt == 3'h0
     && r.phase == spi_front_pkg::PH_STAT_OUT)
    |=> (so_out == $past(status[7])))
    else $error("status byte not shifted out");

  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
    (status_byte[0] == 1'b0) && (status_byte[6:4] == 3'h0)
    && (status_byte[1] == write_enable_flag))
    else $error("status fixed bits wrong");

  write_push_a: assert property (@(posedge clk) disable iff (rst)
    (sck_rise && !r.cs_s[1] && r.phase == spi_front_pkg::PH_WDATA && r.cnt == 3'h7
     && r.we_latch && !is_protected(r.bp, r.addr))
    |=> ##1 (wr_valid || wr_overflow))
    else $error("written byte not queued");

endmodule : spi_front

`default_nettype wire

// File: rtl/spi_front_pkg.sv
// Constants and types shared by the serial memory command front end
package spi_front_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] WRITE_CMD = 8'h02;
  localparam logic [7:0] SLEEP_CMD = 8'hB9;
  localparam logic [7:0] IDENT_READ_CMD = 8'h9F;

  // ----------------------------------------------------------------
  // Status register layout and reset values
  // ----------------------------------------------------------------
  localparam int STAT_WRITE_ENABLE_POS = 1;
  localparam int STAT_BP0_POS = 2;
  localparam int STAT_BP1_POS = 3;
  localparam int STAT_WPEN_POS = 7;
  localparam logic WRITE_ENABLE_RESET = 1'b0;
  localparam logic WPEN_RESET = 1'b0;
  localparam logic [1:0] BP_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Memory geometry and block protection boundaries
  // ----------------------------------------------------------------
  localparam int ADDR_WIDTH = 15;
  localparam int FIFO_DEPTH = 8;
  localparam logic [14:0] QUARTER_BASE = 15'h6000;
  localparam logic [14:0] HALF_BASE = 15'h4000;

  // ----------------------------------------------------------------
  // Frame phases
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_RDATA,
    PH_WDATA,
    PH_STAT_OUT,
    PH_STAT_IN,
    PH_IGNORE
  } phase_type;

endpackage : spi_front_pkg
